// ===== rtl/usb_charge_consts.svh
/*
  Offsets, field positions, reset values and timing counts of the
  charge-mode controller. Assumes a 10 MHz aclk.
*/
`ifndef USB_CHARGE_CONSTS_SVH
`define USB_CHARGE_CONSTS_SVH

`define CLK_PERIOD_NS      100
`define ADDR_STATUS        4'h0
`define ADDR_CTRL          4'h4
`define STAT_MODE_LSB      0
`define STAT_SCHEME_LSB    3
`define STAT_DISCHG_BIT    5
`define STAT_POWER_BIT     6
`define STAT_DATA_BIT      7
`define CTRL_PORT_ALLOW    0
`define CTRL_RESET         32'h0000_0001
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2
`define DEBOUNCE_CYCLES    4
`define DISCHARGE_TIME_US  10
`define V12_TIME_US        20
`define DISCHARGE_CYCLES   ((`DISCHARGE_TIME_US * 1000) / `CLK_PERIOD_NS)
`define V12_CYCLES         ((`V12_TIME_US * 1000) / `CLK_PERIOD_NS)

`endif

// ===== rtl/usb_charge_pkg.sv
/*
  Types of the charge-mode controller: port modes, sequencing states
  and dedicated-charging schemes. Assumes nothing else.
*/
package usb_charge_pkg;

    typedef enum logic [2:0] {
        MODE_RLCO   = 3'h0,
        MODE_DCP    = 3'h1,
        MODE_SDP    = 3'h2,
        MODE_CLIENT = 3'h3,
        MODE_RLDP   = 3'h4,
        MODE_CDP    = 3'h5
    } mode_t;

    typedef enum logic {
        ST_RUN       = 1'b0,
        ST_DISCHARGE = 1'b1
    } seq_state_t;

    typedef enum logic [1:0] {
        SCH_DIVIDER = 2'h0,
        SCH_V12     = 2'h1,
        SCH_SHORTED = 2'h2
    } scheme_t;

endpackage

// ===== rtl/mode_debounce.sv
/*
  Two-flop synchroniser and stability filter for the mode-select code.
  Assumes a single clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module mode_debounce #(
    parameter int W      = 3,
    parameter int STABLE = 4
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] raw,
    output logic      [W-1:0] stable
);

    logic [W-1:0] sync1;
    logic [W-1:0] sync2;
    logic [W-1:0] last;
    logic [7:0]   cnt;
    logic [W-1:0] next_stable;
    logic [7:0]   next_cnt;

    always_comb begin
        next_stable = stable;
        next_cnt    = cnt;
        if (sync2 != last) begin
            next_cnt = 8'h00;
        end else if (cnt < 8'(STABLE - 1)) begin
            next_cnt = cnt + 8'h01;
        end else begin
            next_stable = last;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1  <= '0;
            sync2  <= '0;
            last   <= '0;
            cnt    <= 8'h00;
            stable <= '0;
        end else begin
            sync1  <= raw;
            sync2  <= sync1;
            last   <= sync2;
            cnt    <= next_cnt;
            stable <= next_stable;
        end
    end

endmodule

`default_nettype wire

// ===== rtl/usb_charge_mode_control.sv
/*
  Charging-port mode controller with an AXI4-Lite register slave.
  Assumes one 10 MHz clock, synchronous active-low reset, and that
  attach/release indications from the data-line comparators are
  synchronous to aclk.
*/
// Chosen here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "usb_charge_consts.svh"

module usb_charge_mode_control
    import usb_charge_pkg::*;
#(
    parameter int DISCHARGE_CYC = `DISCHARGE_CYCLES,
    parameter int V12_CYC       = `V12_CYCLES
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        mode_select_bit_a,
    input  wire logic        mode_select_bit_b,
    input  wire logic        mode_select_bit_c,
    input  wire logic        enable,
    input  wire logic        overcurrent,
    input  wire logic        other_fault,
    input  wire logic        shorted_attach,
    input  wire logic        dline_released,
    output logic             ilim_high,
    output logic             status_n,
    output logic             fault_n,
    output logic             cs_enable,
    output logic             power_switch_on,
    output logic             data_switch_on,
    output logic             discharge_on,
    output logic             cdp_autoswitch_en,
    output logic [1:0]       dline_scheme
);

    ////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic mode_t decode(input logic [2:0] c);
        unique case (c)
            3'h0:        decode = MODE_RLCO;
            3'h1:        decode = MODE_DCP;
            3'h2, 3'h3:  decode = MODE_SDP;
            3'h4, 3'h5:  decode = MODE_CLIENT;
            3'h6:        decode = MODE_RLDP;
            default:     decode = MODE_CDP;
        endcase
    endfunction

    function automatic logic exempt(input mode_t a, input mode_t b);
        exempt = ((a == MODE_RLCO || a == MODE_DCP) && (b == MODE_RLCO || b == MODE_DCP))
              || ((a == MODE_RLDP || a == MODE_CDP) && (b == MODE_RLDP || b == MODE_CDP));
    endfunction

    ////////////////////////////////////////////////////////////////////
    // mode input filter

    logic [2:0] code;

    mode_debounce #(
        .W      (3),
        .STABLE (`DEBOUNCE_CYCLES)
    ) u_debounce (
        .aclk    (aclk),
        .aresetn (aresetn),
        .raw     ({mode_select_bit_a, mode_select_bit_b, mode_select_bit_c}),
        .stable  (code)
    );

    ////////////////////////////////////////////////////////////////////
    // mode sequencer

    mode_t       cur_mode;
    mode_t       next_cur_mode;
    seq_state_t  mst;
    seq_state_t  next_mst;
    logic [15:0] dis_cnt;
    logic [15:0] next_dis_cnt;
    mode_t       req_mode;
    logic        code_change;
    logic [31:0] ctrl;

    assign req_mode    = decode(code);
    assign code_change = (mst == ST_RUN) && (req_mode != cur_mode);

    always_comb begin
        next_cur_mode = cur_mode;
        next_mst      = mst;
        next_dis_cnt  = dis_cnt;
        unique case (mst)
            ST_RUN: begin
                if (code_change) begin
                    if (exempt(cur_mode, req_mode)) begin
                        next_cur_mode = req_mode;
                    end else begin
                        next_mst     = ST_DISCHARGE;
                        next_dis_cnt = 16'(DISCHARGE_CYC - 1);
                    end
                end
            end
            ST_DISCHARGE: begin
                if (dis_cnt == 16'h0000) begin
                    next_mst      = ST_RUN;
                    next_cur_mode = req_mode;
                end else begin
                    next_dis_cnt = dis_cnt - 16'h0001;
                end
            end
        endcase
    end

    // client mode at reset keeps the port unpowered until the first discharge ends
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cur_mode <= MODE_CLIENT;
            mst      <= ST_RUN;
            dis_cnt  <= 16'h0000;
        end else begin
            cur_mode <= next_cur_mode;
            mst      <= next_mst;
            dis_cnt  <= next_dis_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // dedicated-charging auto-detect

    scheme_t     dst;
    scheme_t     next_dst;
    logic [15:0] v_cnt;
    logic [15:0] next_v_cnt;
    logic        auto_on;

    // both 000 and 001 run auto-detect
    assign auto_on = (mst == ST_RUN) && (cur_mode == MODE_RLCO || cur_mode == MODE_DCP);

    always_comb begin
        next_dst   = dst;
        next_v_cnt = v_cnt;
        if (!auto_on) begin
            next_dst = SCH_DIVIDER;
        end else begin
            unique case (dst)
                SCH_DIVIDER: begin
                    if (shorted_attach) begin
                        next_dst   = SCH_V12;
                        next_v_cnt = 16'(V12_CYC - 1);
                    end
                end
                SCH_V12: begin
                    if (v_cnt == 16'h0000) begin
                        next_dst = SCH_SHORTED;
                    end else begin
                        next_v_cnt = v_cnt - 16'h0001;
                    end
                end
                SCH_SHORTED: begin
                    if (dline_released) begin
                        next_dst = SCH_DIVIDER;
                    end
                end
                default: next_dst = SCH_DIVIDER;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dst   <= SCH_DIVIDER;
            v_cnt <= 16'h0000;
        end else begin
            dst   <= next_dst;
            v_cnt <= next_v_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pin outputs

    logic next_ilim;
    logic next_status_n;
    logic next_fault_n;
    logic next_cs;
    logic next_power;
    logic next_data;
    logic next_dis;
    logic next_auto_sw;

    always_comb begin
        next_ilim     = 1'b0;
        next_status_n = 1'b1;
        next_cs       = 1'b1;
        next_auto_sw  = 1'b0;
        next_dis      = (mst == ST_DISCHARGE);
        // shorted-scheme entry keeps power on: no discharge here
        next_power    = (mst == ST_RUN) && enable && ctrl[`CTRL_PORT_ALLOW];
        next_data     = 1'b0;
        next_fault_n  = !(other_fault || overcurrent);
        unique case (cur_mode)
            MODE_RLCO: next_fault_n = !other_fault;
            MODE_DCP: begin
                next_ilim     = 1'b1;
                next_status_n = 1'b0;
            end
            MODE_SDP: next_data = 1'b1;
            MODE_RLDP: begin
                next_data    = 1'b1;
                next_fault_n = !other_fault;
            end
            MODE_CDP: begin
                next_ilim     = 1'b1;
                next_status_n = 1'b0;
                next_data     = 1'b1;
                next_auto_sw  = (mst == ST_RUN);
            end
            MODE_CLIENT: begin
                next_cs      = 1'b0;
                next_power   = 1'b0;
                next_data    = 1'b1;
                next_fault_n = 1'b1;
            end
            default: next_fault_n = 1'b1;
        endcase
        next_data = next_data && enable && (mst == ST_RUN);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ilim_high         <= 1'b0;
            status_n          <= 1'b1;
            fault_n           <= 1'b1;
            cs_enable         <= 1'b0;
            power_switch_on   <= 1'b0;
            data_switch_on    <= 1'b0;
            discharge_on      <= 1'b0;
            cdp_autoswitch_en <= 1'b0;
            dline_scheme      <= 2'h0;
        end else begin
            ilim_high         <= next_ilim;
            status_n          <= next_status_n;
            fault_n           <= next_fault_n;
            cs_enable         <= next_cs;
            power_switch_on   <= next_power;
            data_switch_on    <= next_data;
            discharge_on      <= next_dis;
            cdp_autoswitch_en <= next_auto_sw;
            dline_scheme      <= dst;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave

    logic        aw_held;
    logic        w_held;
    logic [3:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        next_aw_held;
    logic        next_w_held;
    logic [3:0]  next_aw_addr;
    logic [31:0] next_w_data;
    logic [3:0]  next_w_strb;
    logic        next_bvalid;
    logic [1:0]  next_bresp;
    logic [31:0] next_ctrl;
    logic        next_arready;
    logic        next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0]  next_rresp;
    logic [31:0] status_word;

    assign status_word = {24'h0, data_switch_on, power_switch_on, discharge_on,
                          dst, cur_mode};

    // one write in flight; address and data may come in either order
    always_comb begin
        next_aw_held = aw_held;
        next_w_held  = w_held;
        next_aw_addr = aw_addr;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_bvalid  = s_axi_bvalid;
        next_bresp   = s_axi_bresp;
        next_ctrl    = ctrl;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (aw_held && w_held && !s_axi_bvalid) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = `RESP_OKAY;
            if (aw_addr == `ADDR_CTRL) begin
                if (w_strb[0]) begin
                    next_ctrl[`CTRL_PORT_ALLOW] = w_data[`CTRL_PORT_ALLOW];
                end
            end else if (aw_addr != `ADDR_STATUS) begin
                next_bresp = `RESP_SLVERR;
            end
        end else if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
    end

    always_comb begin
        next_rvalid  = s_axi_rvalid;
        next_rdata   = s_axi_rdata;
        next_rresp   = s_axi_rresp;
        next_arready = !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp  = `RESP_OKAY;
            unique case (s_axi_araddr)
                `ADDR_STATUS: next_rdata = status_word;
                `ADDR_CTRL:   next_rdata = ctrl;
                default: begin
                    next_rdata = 32'h0;
                    next_rresp = `RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid  = 1'b0;
            next_arready = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 4'h0;
            w_data        <= 32'h0;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
            ctrl          <= `CTRL_RESET;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= 2'h0;
        end else begin
            aw_held       <= next_aw_held;
            w_held        <= next_w_held;
            aw_addr       <= next_aw_addr;
            w_data        <= next_w_data;
            w_strb        <= next_w_strb;
            s_axi_awready <= !next_aw_held && !next_bvalid;
            s_axi_wready  <= !next_w_held && !next_bvalid;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
            ctrl          <= next_ctrl;
            s_axi_arready <= next_arready;
            s_axi_rvalid  <= next_rvalid;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks

    // follows the instance override so the check tracks the real interval
    localparam int V12_LEN = V12_CYC;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_client_outputs: assert property (
        cur_mode == MODE_CLIENT |=> !power_switch_on && status_n && fault_n && !cs_enable)
        else $error("client mode outputs wrong");

    chk_reduced_no_oc: assert property (
        (cur_mode == MODE_RLCO || cur_mode == MODE_RLDP) && !other_fault |=> fault_n)
        else $error("overcurrent flagged in reduced mode");

    chk_high_limit: assert property (
        cur_mode == MODE_CDP |=> ilim_high && !status_n && cs_enable)
        else $error("charging port limit or status wrong");

    chk_exempt_live: assert property (
        code_change && exempt(cur_mode, req_mode) |=> mst == ST_RUN && !discharge_on)
        else $error("exempt change discharged");

    chk_change_discharge: assert property (
        code_change && !exempt(cur_mode, req_mode)
        |=> mst == ST_DISCHARGE ##1 discharge_on && !power_switch_on)
        else $error("mode change without discharge");

    chk_data_open: assert property (
        !enable || mst == ST_DISCHARGE || cur_mode == MODE_DCP |=> !data_switch_on)
        else $error("data switch closed when forbidden");

    chk_data_closed: assert property (
        enable && mst == ST_RUN && (cur_mode == MODE_CDP || cur_mode == MODE_SDP
        || cur_mode == MODE_CLIENT) |=> data_switch_on)
        else $error("data switch open in data mode");

    chk_v12_time: assert property (
        $rose(dst == SCH_V12) |-> ##V12_LEN (dst == SCH_SHORTED || !auto_on
        || $past(!auto_on)))
        else $error("1.2 V interval wrong");

    chk_shorted_hold: assert property (
        dst == SCH_SHORTED && auto_on && !dline_released |=> dst == SCH_SHORTED)
        else $error("left shorted mode early");

    chk_divider_entry: assert property (
        !auto_on ##1 auto_on |-> dst == SCH_DIVIDER)
        else $error("auto-detect not started in divider");

    cov_shorted: cover property (dst == SCH_V12 ##[1:300] dst == SCH_SHORTED);
    cov_discharge: cover property (mst == ST_DISCHARGE ##1 mst == ST_RUN);
    cov_exempt: cover property (code_change && exempt(cur_mode, req_mode));
    cov_client: cover property (cur_mode == MODE_CLIENT && data_switch_on);

endmodule

`default_nettype wire

// ===== testbench/portable_device.sv
/*
  Model of the portable device on the charging port.
  Assumes the bench picks the attached kind: 0 none, 1 divider, 2 shorted.
*/
`timescale 1ns/1ps
`default_nettype none
module portable_device (
    input  wire logic       aclk,
    input  wire logic [1:0] kind,
    output logic            shorted_attach,
    output logic            dline_released
);
    logic [1:0] prev;
    always_ff @(posedge aclk) begin
        prev           <= kind;
        shorted_attach <= (kind == 2'h2);
        dline_released <= (prev == 2'h2) && (kind != 2'h2);
    end
endmodule
`default_nettype wire

// ===== testbench/tb_usb_charge_mode_control.sv
/*
  Bench for the charge-mode controller: mode table, discharge rules,
  fault masking, auto-detect schemes and the register bus.
  Assumes the portable device model beside it.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_usb_charge_mode_control;
    logic        aclk, aresetn, awv, wv, br, arv, rr, en, oc, of;
    logic [3:0]  awa, ara;
    logic [31:0] wd, rd;
    logic [2:0]  code;
    logic [1:0]  kind, bresp, rresp, sch;
    logic        awr, wr, bv, arr, rv, ilim, st_n, f_n, cs, pw, dsw, dis, asw;
    logic        sa, rel, seen, seen_clr;
    int          miscompares = 0;
    int          cmp_count = 0;
    usb_charge_mode_control #(.DISCHARGE_CYC(4)) usb_charge_mode_control_inst (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
        .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
        .mode_select_bit_a(code[2]), .mode_select_bit_b(code[1]),
        .mode_select_bit_c(code[0]), .enable(en), .overcurrent(oc), .other_fault(of),
        .shorted_attach(sa), .dline_released(rel), .ilim_high(ilim), .status_n(st_n),
        .fault_n(f_n), .cs_enable(cs), .power_switch_on(pw), .data_switch_on(dsw),
        .discharge_on(dis), .cdp_autoswitch_en(asw), .dline_scheme(sch));
    portable_device portable_device_inst (
        .aclk(aclk), .kind(kind), .shorted_attach(sa), .dline_released(rel));
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        aclk = 0;
        forever #50 aclk = ~aclk;
    end
    // sticky discharge flag, cleared only through seen_clr
    always @(posedge aclk) seen <= !seen_clr && (seen || dis === 1'b1);
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic clr();
        seen_clr <= 1'b1;
        cyc(1);
        seen_clr <= 1'b0;
    endtask
    task automatic mode(input logic [2:0] c);
        code <= c;
        clr();
        cyc(29);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
        int n;
        awa <= a; wd <= d; awv <= 1; wv <= 1; br <= 1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (awv && awr) awv <= 0;
            if (wv && wr) wv <= 0;
            if (bv) break;
        end
        br <= 0;
        if (n == 100) begin miscompares++; report_and_stop(); end
        chk("bresp", bresp, e);
        cyc(1);
    endtask
    task automatic axr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
        int n;
        ara <= a; arv <= 1; rr <= 1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (arv && arr) arv <= 0;
            if (rv) break;
        end
        rr <= 0;
        if (n == 100) begin miscompares++; report_and_stop(); end
        chk("rdata", rd, d);
        chk("rresp", rresp, e);
        cyc(1);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_table();
        logic hi, cl, dt;
        for (int c = 0; c < 8; c++) begin
            mode(3'(c));
            hi = (c == 1 || c == 7);
            cl = (c == 4 || c == 5);
            dt = (c >= 2);
            chk("ilim", ilim, hi & !cl);
            chk("status_n", st_n, !hi);
            chk("cs", cs, !cl);
            chk("power", pw, !cl);
            chk("data", dsw, dt);
            chk("autosw", asw, c == 7);
        end
        en <= 0;
        cyc(3);
        chk("data_off", dsw, 0);
        en <= 1;
        $display("test table done");
    endtask
    task automatic t_discharge();
        mode(3'h6); mode(3'h7); chk("dis_67", seen, 0);
        mode(3'h6); chk("dis_76", seen, 0);
        mode(3'h0); chk("dis_60", seen, 1);
        mode(3'h1); chk("dis_01", seen, 0);
        mode(3'h0); chk("dis_10", seen, 0);
        $display("test discharge done");
    endtask
    task automatic t_fault();
        oc <= 1; cyc(3); chk("oc_000", f_n, 1);
        of <= 1; cyc(3); chk("of_000", f_n, 0);
        of <= 0; mode(3'h6); chk("oc_110", f_n, 1);
        mode(3'h1); chk("oc_001", f_n, 0);
        oc <= 0; cyc(3);
        $display("test fault done");
    endtask
    task automatic t_auto();
        clr();
        kind <= 2'h1; cyc(20); chk("div", sch, 0);
        kind <= 2'h2; cyc(6); chk("v12", sch, 1);
        cyc(210); chk("short", sch, 2);
        chk("pw_kept", pw, 1);
        chk("dis_none", seen, 0);
        kind <= 2'h0; cyc(6); chk("back", sch, 0);
        $display("test auto done");
    endtask
    task automatic t_regs();
        axr(4'h0, 32'h41, 2'h0);
        axw(4'h4, 32'h0, 2'h0);
        cyc(3); chk("pw_gate", pw, 0);
        axr(4'h4, 32'h0, 2'h0);
        axw(4'h4, 32'h1, 2'h0);
        axw(4'h0, 32'hff, 2'h0);
        axr(4'h8, 32'h0, 2'h2);
        axw(4'hc, 32'h1, 2'h2);
        $display("test regs done");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        aresetn = 0; awv = 0; wv = 0; br = 0; arv = 0; rr = 0; en = 1; oc = 0;
        of = 0; awa = 0; ara = 0; wd = 0; code = 0; kind = 0; seen_clr = 1;
        cyc(10);
        aresetn <= 1;
        t_table();
        t_discharge();
        t_fault();
        t_auto();
        t_regs();
        report_and_stop();
    end
endmodule
`default_nettype wire
